/* rtl/scl_pkg.sv */
package scl_pkg;
    // register addresses and reset values
    localparam logic [7:0] CTRL_ADDR  = 8'hf8;
    localparam logic [7:0] DATA_ADDR  = 8'ha3;
    localparam logic [7:0] CTRL_RESET = 8'h06;
    localparam logic [7:0] DATA_RESET = 8'h00;
    // control/status field positions
    localparam int DONE_BIT    = 7;
    localparam int WRITE_COLLISION_FLAG_BIT    = 6;
    localparam int MODE_FAULT_FLAG_BIT    = 5;
    localparam int OVR_BIT     = 4;
    localparam int MODE_HI_BIT = 3;
    localparam int MODE_LO_BIT = 2;
    localparam int TXE_BIT     = 1;
    localparam int EN_BIT      = 0;
    localparam logic [7:0] TXE_MASK = 8'h01 << TXE_BIT;
    // bit-address select width inside the bit-addressable register
    localparam int BIT_SEL_W   = 3;
    // serial word size
    localparam int BYTE_W      = 8;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // slave-select wiring modes
    typedef enum logic [1:0] {
        SCL_3WIRE    = 2'b00,
        SCL_4W_SLAVE = 2'b01,
        SCL_4W_OUT_0 = 2'b10,
        SCL_4W_OUT_1 = 2'b11
    } scl_mode_t;

    // byte-wide register access
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } scl_sfr_req_t;

    // single-bit access to the bit-addressable register
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic       val;
    } scl_bit_req_t;
endpackage

/* rtl/scl_sync.sv */
`timescale 1ns/1ps
// two-flop synchroniser, first stage read only by second
module scl_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         arst_n,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    // two stages
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_q <= '0;
            q      <= '0;
        end
        else
        begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

/* rtl/scl_spi_ctrl.sv */
// Notes on behaviour
// - Transfer-done flag sets at the end of every byte and stays set until software writes it to zero.
// - A data write while the transmit buffer is full sets the sticky write-collision flag and is dropped.
// - A byte completing while the receive buffer is unread sets the sticky receive-overrun flag.
// - The receive-overrun flag raises the interrupt request just as the transfer-done flag does.
// - Select mode 00 is three-wire, 01 is four-wire with select as input, 1x drives select from the low mode bit.
`timescale 1ns/1ps
module scl_spi_ctrl (
    // system clock and reset
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    // register access
    input  wire scl_pkg::scl_sfr_req_t sfr_req,
    input  wire scl_pkg::scl_bit_req_t bit_req,
    output logic [7:0]                 sfr_rdata,
    // from configuration logic
    input  wire logic                  master_en,
    // serial link
    input  wire logic                  link_clk,
    input  wire logic                  mosi_i,
    output logic                       miso_o,
    output logic                       miso_oe_n,
    // slave-select line
    input  wire logic                  ss_i,
    output logic                       ss_o,
    output logic                       ss_oe_n,
    // interrupt request
    output logic                       irq
);
    import scl_pkg::*;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // system-domain state
    logic [7:0]   ctrl_q;
    logic [7:0]   ctrl_d;
    logic [7:0]   tx_buf_q;
    logic [7:0]   rx_buf_q;
    logic         rx_full_q;
    logic         rx_full_d;
    logic         req_tgl_q;
    logic         req_tgl_d;
    logic         done_seen_q;
    logic         active_q;
    logic         active_d;
    logic [7:0]   rdata_d;
    logic         irq_q;
    logic         ss_o_q;
    logic         ss_oe_n_q;
    logic         miso_oe_n_q;
    // crossing results in the system domain
    logic         ss_s;
    logic         done_s;
    logic         ack_s;
    // link-domain state
    logic [2:0]   bit_cnt_q;
    logic [6:0]   rx_sh_q;
    logic [7:0]   rx_word_q;
    logic [7:0]   tx_sh_q;
    logic         done_tgl_q;
    logic         taken_q;
    logic         act_l;
    logic         req_l;

    // pin and event synchronisers into the system domain
    scl_sync #(.W(1)) u_ss_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .d      (ss_i),
        .q      (ss_s)
    );
    scl_sync #(.W(2)) u_evt_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .d      ({done_tgl_q, taken_q}),
        .q      ({done_s, ack_s})
    );
    // enable level and transmit request into the link domain
    scl_sync #(.W(2)) u_link_sync (
        .clk    (link_clk),
        .arst_n (arst_n),
        .d      ({active_q, req_tgl_q}),
        .q      ({act_l, req_l})
    );

    // register decode
    wire         byte_wr   = sfr_req.wr && (sfr_req.addr == CTRL_ADDR);
    wire         bit_wr    = bit_req.wr && (bit_req.addr[7:BIT_SEL_W] == CTRL_ADDR[7:BIT_SEL_W]);
    wire         data_wr   = sfr_req.wr && (sfr_req.addr == DATA_ADDR);
    wire         data_rd   = sfr_req.rd && (sfr_req.addr == DATA_ADDR);
    wire         ctrl_rd   = sfr_req.rd && (sfr_req.addr == CTRL_ADDR);
    wire [7:0]   bit_mask  = {7'h00, bit_wr} << bit_req.addr[BIT_SEL_W-1:0];
    wire [7:0]   wr_mask   = byte_wr ? {8{1'b1}} : bit_mask;
    wire [7:0]   wr_val    = byte_wr ? sfr_req.wdata : {8{bit_req.val}};

    // current control fields
    wire         port_en   = ctrl_q[EN_BIT];
    wire [1:0]   mode_bits = {ctrl_q[MODE_HI_BIT], ctrl_q[MODE_LO_BIT]};
    wire         mode_3w   = (mode_bits == SCL_3WIRE);
    wire         mode_4ws  = (mode_bits == SCL_4W_SLAVE);
    wire         mode_out  = ctrl_q[MODE_HI_BIT];

    // transmit buffer handshake
    wire         tx_full   = req_tgl_q ^ ack_s;
    wire         tx_accept = data_wr && !tx_full;
    wire         write_collision_flag_set  = data_wr && tx_full;
    assign       req_tgl_d = req_tgl_q ^ tx_accept;
    wire         tx_full_d = req_tgl_d ^ ack_s;

    // byte completion and receive buffer
    wire         done_pulse = done_s ^ done_seen_q;
    wire         ovr_set    = done_pulse && rx_full_q && !data_rd;
    wire         rx_load    = done_pulse && !ovr_set;
    assign       rx_full_d  = rx_load || (rx_full_q && !data_rd);

    // mode fault: select pulled low while mastering in four-wire slave wiring
    wire         mode_fault_flag_set   = port_en && master_en && mode_4ws && !ss_s;

    // port selection
    wire         selected   = mode_3w || (mode_4ws && !ss_s);
    assign       active_d   = port_en && selected;

    // hardware sets win over software clears
    wire [7:0]   sw_next  = (ctrl_q & ~wr_mask) | (wr_val & wr_mask);
    wire [7:0]   hw_set   = ({7'h00, done_pulse} << DONE_BIT) |
                            ({7'h00, write_collision_flag_set}   << WRITE_COLLISION_FLAG_BIT) |
                            ({7'h00, mode_fault_flag_set}   << MODE_FAULT_FLAG_BIT) |
                            ({7'h00, ovr_set}    << OVR_BIT);
    assign       ctrl_d   = ((sw_next | hw_set) & ~TXE_MASK) | ({8{~tx_full_d}} & TXE_MASK);

    // read data selection
    assign       rdata_d  = data_rd ? rx_buf_q : (ctrl_rd ? ctrl_q : sfr_rdata);

    // any pending flag requests service
    wire         irq_d    = ctrl_q[DONE_BIT] | ctrl_q[WRITE_COLLISION_FLAG_BIT] |
                            ctrl_q[MODE_FAULT_FLAG_BIT] | ctrl_q[OVR_BIT];

    // control and status register
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            ctrl_q <= CTRL_RESET;
        else
            ctrl_q <= ctrl_d;
    end

    // transmit buffer, written only while empty
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_buf_q  <= DATA_RESET;
            req_tgl_q <= 1'b0;
        end
        else
        begin
            if (tx_accept)
                tx_buf_q <= sfr_req.wdata;
            req_tgl_q <= req_tgl_d;
        end
    end

    // receive buffer; a byte arriving over unread data is dropped
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_buf_q    <= DATA_RESET;
            rx_full_q   <= 1'b0;
            done_seen_q <= 1'b0;
        end
        else
        begin
            if (rx_load)
                rx_buf_q <= rx_word_q;
            rx_full_q   <= rx_full_d;
            done_seen_q <= done_s;
        end
    end

    // registered outputs of the system domain
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sfr_rdata   <= DATA_RESET;
            irq_q       <= 1'b0;
            active_q    <= 1'b0;
            ss_o_q      <= 1'b1;
            ss_oe_n_q   <= 1'b1;
            miso_oe_n_q <= 1'b1;
        end
        else
        begin
            sfr_rdata   <= rdata_d;
            irq_q       <= irq_d;
            active_q    <= active_d;
            ss_o_q      <= ctrl_q[MODE_LO_BIT];
            ss_oe_n_q   <= !(port_en && mode_out);
            miso_oe_n_q <= !active_d;
        end
    end

    assign irq       = irq_q;
    assign ss_o      = ss_o_q;
    assign ss_oe_n   = ss_oe_n_q;
    assign miso_oe_n = miso_oe_n_q;

    // link side: next transmit word is taken at byte boundaries, or at any link edge while inactive
    wire         byte_end = act_l && (bit_cnt_q == LAST_BIT);
    wire         tx_load  = (!act_l || byte_end) && (req_l != taken_q);
    wire [7:0]   tx_next  = tx_load ? tx_buf_q : {tx_sh_q[6:0], 1'b0};

    // receive shift and byte completion event
    always_ff @(posedge link_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bit_cnt_q  <= 3'h0;
            rx_sh_q    <= 7'h00;
            rx_word_q  <= DATA_RESET;
            done_tgl_q <= 1'b0;
        end
        else if (!act_l)
            bit_cnt_q  <= 3'h0;
        else
        begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            rx_sh_q   <= {rx_sh_q[5:0], mosi_i};
            if (byte_end)
            begin
                rx_word_q  <= {rx_sh_q, mosi_i};
                done_tgl_q <= ~done_tgl_q;
            end
        end
    end

    // transmit shift, most significant bit first
    always_ff @(posedge link_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_sh_q <= DATA_RESET;
            taken_q <= 1'b0;
        end
        else
        begin
            if (act_l || tx_load)
                tx_sh_q <= tx_next;
            if (tx_load)
                taken_q <= ~taken_q;
        end
    end

    assign miso_o = tx_sh_q[BYTE_W-1];

    // checks
    done_set_a: assert property (done_pulse |=> ctrl_q[DONE_BIT])
        else $error("transfer done flag not set after byte");
    done_sticky_a: assert property (ctrl_q[DONE_BIT] && !(wr_mask[DONE_BIT] && !wr_val[DONE_BIT])
        |=> ctrl_q[DONE_BIT])
        else $error("transfer done flag cleared without software");
    write_collision_flag_set_a: assert property (data_wr && tx_full |=> ctrl_q[WRITE_COLLISION_FLAG_BIT] && $stable(tx_buf_q))
        else $error("collision not flagged or data overwritten");
    write_collision_flag_sticky_a: assert property (ctrl_q[WRITE_COLLISION_FLAG_BIT] && !wr_mask[WRITE_COLLISION_FLAG_BIT] |=> ctrl_q[WRITE_COLLISION_FLAG_BIT])
        else $error("collision flag dropped by itself");
    ovr_set_a: assert property (done_pulse && rx_full_q && !data_rd |=> ctrl_q[OVR_BIT] && rx_full_q)
        else $error("overrun not flagged");
    ovr_irq_a: assert property ($rose(ctrl_q[OVR_BIT]) |=> irq ##1 (irq || !ctrl_q[OVR_BIT]))
        else $error("overrun did not raise interrupt");
    select_drive_a: assert property (port_en && mode_out |=> !ss_oe_n && ss_o == $past(ctrl_q[MODE_LO_BIT]))
        else $error("select line not driven in output mode");
    port_off_a: assert property (!port_en |=> !active_q && miso_oe_n)
        else $error("port active while disabled");

    // transfer done raises the request
    done_irq_a: assert property (ctrl_q[DONE_BIT] |=> irq)
        else $error("transfer done flag did not raise interrupt");
    // overrun keeps the unread byte
    ovr_keep_a: assert property (ovr_set |=> $stable(rx_buf_q))
        else $error("unread byte overwritten on overrun");
    // overrun flag only cleared by software
    ovr_sticky_a: assert property (ctrl_q[OVR_BIT] && !wr_mask[OVR_BIT] |=> ctrl_q[OVR_BIT])
        else $error("overrun flag dropped by itself");
    // accepted write marks the buffer occupied
    txe_clear_a: assert property (tx_accept |=> !ctrl_q[TXE_BIT])
        else $error("transmit buffer still shown empty after write");
    // three-wire wiring needs no select
    three_wire_a: assert property (port_en && mode_3w |=> active_q)
        else $error("three-wire port not active");
    // released select keeps four-wire slave idle
    select_gate_a: assert property (mode_4ws && ss_s |=> !active_q)
        else $error("port active with select released");
    // select-driving wiring never takes a transfer here
    out_mode_a: assert property (mode_out |=> !active_q)
        else $error("port active while driving select");

    // link side held idle while inactive
    link_idle_a: assert property (@(posedge link_clk) disable iff (!arst_n) !act_l |=> bit_cnt_q == 3'h0)
        else $error("bit counter moved while port inactive");
endmodule

/* dv/scl_link_master.sv */
`timescale 1ns/1ps
// link master model, serial clock runs only during xfer, select set separately
module scl_link_master (
    // serial link towards the port
    output logic      link_clk,
    output logic      mosi_i,
    output logic      ss_i,
    // serial data back from the port
    input  wire logic miso_o
);
    // idle link, select released
    initial
    begin
        link_clk = 1'b0;
        mosi_i   = 1'b0;
        ss_i     = 1'b1;
    end

    // select line level, low selects the port
    task automatic set_select(input logic lvl);
        ss_i = lvl;
    endtask

    // n edges msb first, miso sampled before each rising edge
    task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = n - 1; i >= 0; i--)
        begin
            mosi_i = tx[i % 8];
            #24;
            rx[i % 8] = miso_o;
            link_clk = 1'b1;
            #24;
            link_clk = 1'b0;
        end
        mosi_i = ~mosi_i; // released line shows no stale bit
    endtask
endmodule

/* dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import scl_pkg::*;
    logic         clk;
    logic         arst_n;
    logic         master_en;
    logic         link_clk;
    logic         mosi_i;
    logic         ss_i;
    logic         miso_o;
    logic         miso_oe_n;
    logic         ss_o;
    logic         ss_oe_n;
    logic         irq;
    logic [7:0]   sfr_rdata;
    logic [7:0]   rx;
    logic [7:0]   q;
    scl_sfr_req_t sfr_req;
    scl_bit_req_t bit_req;
    int           mismatches;
    int           comparisons;

    // system clock, 100 ns
    initial clk = 1'b0;
    always #50 clk = ~clk;

    scl_spi_ctrl dut_u (.clk(clk), .arst_n(arst_n), .sfr_req(sfr_req), .bit_req(bit_req),
        .sfr_rdata(sfr_rdata), .master_en(master_en), .link_clk(link_clk), .mosi_i(mosi_i),
        .miso_o(miso_o), .miso_oe_n(miso_oe_n), .ss_i(ss_i), .ss_o(ss_o), .ss_oe_n(ss_oe_n), .irq(irq));
    scl_link_master mdl_u (.link_clk(link_clk), .mosi_i(mosi_i), .ss_i(ss_i), .miso_o(miso_o));

    // verdict and end of run
    task automatic tally_and_finish();
        if (mismatches == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // k: 0 byte write, 1 byte read, 2 bit write; one idle cycle after
    task automatic bus(input int k, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
        sfr_req = '{k == 0, k == 1, a, d};
        bit_req = '{k == 2, a, d[0]};
        @(posedge clk);
        #1;
        sfr_req = '0;
        bit_req = '0;
        @(posedge clk);
        #1;
        r = sfr_rdata;
    endtask

    // bounded poll of one control bit
    task automatic wait_ctl(input int b);
        logic [7:0] r;
        @(posedge clk);
        #1;
        for (int n = 0; n < 20; n++)
        begin
            bus(1, CTRL_ADDR, 8'h00, r);
            if (r[b] === 1'b1)
                return;
        end
        mismatches++;
        tally_and_finish();
    endtask

    task automatic t_reset();
        bus(1, CTRL_ADDR, 8'h00, q);
        check(q, CTRL_RESET);
        check({5'h00, ss_oe_n, miso_oe_n, irq}, 8'h06);
    endtask

    task automatic t_modes();
        for (int m = 0; m < 4; m++)
        begin
            mdl_u.set_select(m[1]);
            bus(0, CTRL_ADDR, {4'h0, m[1:0], 2'b01}, q);
            repeat (4) @(posedge clk);
            #1;
            check({5'h00, ss_oe_n, m[1] & ss_o, miso_oe_n}, {5'h00, ~m[1], m[1] & m[0], m[1]});
        end
        bus(0, CTRL_ADDR, 8'h05, q);
        repeat (4) @(posedge clk);
        #1;
        check({7'h00, miso_oe_n}, 8'h01);
    endtask

    task automatic t_disabled();
        bus(0, CTRL_ADDR, 8'h00, q);
        mdl_u.xfer(8'h96, 10, rx);
        repeat (10) @(posedge clk);
        #1;
        bus(1, CTRL_ADDR, 8'h00, q);
        check({q[7:4], 3'h0, miso_oe_n}, 8'h01);
    endtask

    task automatic t_xfer();
        bus(0, DATA_ADDR, 8'ha5, q);
        bus(0, DATA_ADDR, 8'h3c, q);
        bus(1, CTRL_ADDR, 8'h00, q);
        check(q, 8'h40);
        mdl_u.xfer(8'h00, 3, rx);
        repeat (4) @(posedge clk);
        #1;
        bus(0, CTRL_ADDR, 8'h41, q);
        bus(1, CTRL_ADDR, 8'h00, q);
        check(q, 8'h43);
        check({7'h00, irq}, 8'h01);
        bus(2, 8'hfe, 8'h00, q);
        mdl_u.xfer(8'h00, 2, rx);
        mdl_u.xfer(8'hc3, 8, rx);
        wait_ctl(DONE_BIT);
        check(rx, 8'ha5);
        repeat (20) @(posedge clk);
        #1;
        bus(1, CTRL_ADDR, 8'h00, q);
        check(q & 8'hc2, 8'h82);
        bus(2, 8'hff, 8'h00, q);
        bus(1, CTRL_ADDR, 8'h00, q);
        check(q & 8'h80, 8'h00);
    endtask

    task automatic t_overrun();
        mdl_u.xfer(8'h5a, 8, rx);
        wait_ctl(OVR_BIT);
        bus(2, 8'hff, 8'h00, q);
        bus(1, CTRL_ADDR, 8'h00, q);
        check({q[7], 6'h00, irq}, 8'h01);
        bus(1, DATA_ADDR, 8'h00, q);
        check(q, 8'hc3);
        bus(2, 8'hfc, 8'h00, q);
        bus(1, CTRL_ADDR, 8'h00, q);
        check({q[7:4], 3'h0, irq}, 8'h00);
    endtask

    // main sequence, link edges given during reset
    initial
    begin
        arst_n = 1'b0;
        master_en = 1'b0;
        sfr_req = '0;
        bit_req = '0;
        mismatches = 0;
        comparisons = 0;
        mdl_u.xfer(8'h00, 2, rx);
        repeat (4) @(posedge clk);
        #1;
        arst_n = 1'b1;
        t_reset();
        t_modes();
        t_disabled();
        t_xfer();
        t_overrun();
        tally_and_finish();
    end

    // hang guard
    initial
    begin
        #2000000;
        mismatches++;
        tally_and_finish();
    end
endmodule
